/* File: src/ldc_pkg.sv */
// Purpose: Shared constants and types of the logical DMA channel router
// Assumes: Wishbone byte address is four times the register index
// Notes: Mode, strobe and select registers reset to zero

package ldc_pkg;

  // --------------------------------------------------------------
  // Register indices
  // --------------------------------------------------------------
  localparam logic [5:0] IDX_STROBE = 6'h01;
  localparam logic [5:0] IDX_MODE_A = 6'h03;
  localparam logic [5:0] IDX_MODE_B = 6'h05;
  localparam logic [5:0] IDX_MODE_C = 6'h07;
  localparam logic [5:0] IDX_AIAO_SEL = 6'h09;
  localparam logic [5:0] IDX_CTR_SEL = 6'h0B;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h0C;
  localparam logic [5:0] IDX_IRQ_CLR = 6'h0D;
  localparam logic [5:0] IDX_IRQ_EN = 6'h0E;
  localparam logic [5:0] IDX_CHAN_STAT = 6'h0F;
  localparam logic [17:0] IDX_MODES = {IDX_MODE_C, IDX_MODE_B, IDX_MODE_A};

  // --------------------------------------------------------------
  // Field positions and sizes
  // --------------------------------------------------------------
  localparam int unsigned LCH_N = 3;
  localparam int unsigned PHYS_N = 8;
  localparam int unsigned SEL_IN_LSB = 0;
  localparam int unsigned SEL_OUT_LSB = 4;
  localparam int unsigned CSTAT_DRQ_LSB = 4;

  // --------------------------------------------------------------
  // Reset values and codes
  // --------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [2:0] STROBE_RST = 3'h0;
  localparam logic [2:0] IRQ_EN_RST = 3'h7;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  localparam logic [2:0] XFER_SINGLE = 3'h0;
  localparam logic [2:0] XFER_BURST = 3'h1;
  localparam int unsigned BURST_MAX = 8;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef struct packed {
    logic on;
    logic irq_on;
    logic [2:0] xfer;
    logic [2:0] phys;
  } ldc_mode_t;

  typedef struct packed {
    logic g1;
    logic g0;
    logic ao;
    logic ai;
  } ldc_res_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_GAP = 2'b10
  } ldc_state_t;

endpackage

/* File: src/ldc_chan.sv */
// Purpose: Request engine of one logical DMA channel
// Assumes: dack_i and tc_i are already synchronised and filtered
// Notes: drq_o is combinational; the top registers it

`timescale 1ns/1ps

module ldc_chan #(
  parameter int unsigned BURST_LEN = ldc_pkg::BURST_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ldc_pkg::ldc_mode_t mode_i,
  input wire logic lreq_i,
  input wire logic dack_i,
  input wire logic tc_i,
  output logic drq_o,
  output logic lack_o,
  output logic tc_ev_o
);
  import ldc_pkg::*;

  ldc_state_t state;
  ldc_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic ack_q;
  logic tc_q;

  wire ack_rise = dack_i & ~ack_q;
  wire tc_hit = mode_i.on & dack_i & tc_i;
  wire burst = mode_i.xfer == XFER_BURST;
  wire last = !burst || cnt == 3'(BURST_LEN - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      ack_q <= 1'b0;
      tc_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ack_q <= dack_i;
      tc_q <= tc_hit;
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_IDLE: begin
        if (mode_i.on && lreq_i) begin
          next_state = ST_REQ;
          next_cnt = 3'h0;
        end
      end
      ST_REQ: begin
        if (ack_rise) begin
          next_cnt = 3'(cnt + 3'h1);
          if (last) begin
            next_state = ST_GAP;
          end
        end else if (burst && !lreq_i && !dack_i) begin
          next_state = ST_IDLE;
        end
      end
      ST_GAP: begin
        if (!dack_i) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!mode_i.on) begin
      next_state = ST_IDLE;
      next_cnt = 3'h0;
    end
  end

  assign drq_o = state == ST_REQ;
  assign lack_o = mode_i.on & dack_i;
  assign tc_ev_o = tc_hit & ~tc_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  chk_single_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_REQ && !burst && ack_rise && mode_i.on |=> state == ST_GAP)
    else $error("single transfer did not release the request");

  chk_burst_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_REQ && burst && ack_rise && mode_i.on && cnt == 3'(BURST_LEN - 1) |=> !drq_o)
    else $error("burst held past eight transfers");

  chk_off_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_i.on |=> !drq_o)
    else $error("disabled channel requested");

  cov_burst_done: cover property (@(posedge clk_i) disable iff (rst_i)
    state == ST_REQ && burst && ack_rise && cnt == 3'(BURST_LEN - 1));

endmodule // ldc_chan

/* File: src/ldc_top.sv */
// Purpose: Routes three logical DMA channels onto physical DMA lines
// Assumes: Classic Wishbone slave, 32-bit data, registers in byte lane 0
// Notes: dack_i and tc_i come from pins and are synchronised here
//
// Behaviour
// - Three independent logical channels each map onto any selectable 16-bit physical channel.
// - Select registers bind the analog input, analog output and counter resources to logical channels.
// - A one in strobe bit 0, 1 or 2 clears the terminal-count status and interrupt of channel A, B or C.
// - Strobe bits return to zero by themselves after every write.
// - Strobe and mode registers are all zero after reset.
// - An enabled channel forwards its requests to the selected physical line, a disabled one ignores them.
// - With its interrupt enable set a channel raises an interrupt on terminal count, otherwise not; the code needs both mode irq_on and the irq_en bit set.
// - Transfer type 0 requests single transfers and type 1 holds the request for up to eight.
// - The physical channel field picks the driven line and software uses only 16-bit channel codes.
// - Channels B and C have mode registers like channel A at offsets 05 and 07.
//
// Design decision made here: the Wishbone slave port.

`timescale 1ns/1ps

module ldc_top #(
  parameter int unsigned BURST_LEN = ldc_pkg::BURST_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ldc_pkg::ldc_res_t res_req_i,
  output ldc_pkg::ldc_res_t res_ack_o,
  output logic [ldc_pkg::PHYS_N-1:0] drq_o,
  input wire logic [ldc_pkg::PHYS_N-1:0] dack_i,
  input wire logic tc_i,
  output logic irq_o
);
  import ldc_pkg::*;

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  ldc_mode_t mode [LCH_N];
  logic [7:0] aiao_sel;
  logic [7:0] ctr_sel;
  logic [2:0] strb;
  logic [2:0] irq_en;
  logic [2:0] tc_stat;
  logic [PHYS_N:0] s1;
  logic [PHYS_N:0] s2;
  logic [PHYS_N:0] s3;
  logic [PHYS_N:0] filt;
  logic [PHYS_N-1:0] next_drq;
  logic [LCH_N-1:0] lreq;
  logic [LCH_N-1:0] drq_c;
  logic [LCH_N-1:0] lack;
  logic [LCH_N-1:0] tc_ev;
  logic [LCH_N-1:0] on_vec;
  logic [LCH_N-1:0] irq_on_vec;
  ldc_res_t next_res_ack;

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  wire [PHYS_N:0] pins = {tc_i, dack_i};
  wire [PHYS_N:0] agree = ~(s2 ^ s3);
  wire [PHYS_N:0] next_filt = (s2 & agree) | (filt & ~agree);
  wire [PHYS_N-1:0] dack_f = filt[PHYS_N-1:0];
  wire tc_f = filt[PHYS_N];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end

  // --------------------------------------------------------------
  // Wishbone decode
  // --------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i;
  wire [5:0] idx = wb_adr_i[7:2];
  wire first = req & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire hit_strobe = idx == IDX_STROBE;
  wire hit_aiao = idx == IDX_AIAO_SEL;
  wire hit_ctr = idx == IDX_CTR_SEL;
  wire hit_irq_stat = idx == IDX_IRQ_STAT;
  wire hit_irq_clr = idx == IDX_IRQ_CLR;
  wire hit_irq_en = idx == IDX_IRQ_EN;
  wire hit_chan_stat = idx == IDX_CHAN_STAT;

  wire [31:0] rd_stat = {29'h0, tc_stat};
  wire [31:0] rd_en = {29'h0, irq_en};
  wire [31:0] rd_chan = {25'h0, drq_c, 1'b0, on_vec};
  wire [31:0] next_rdata =
    hit_irq_stat ? rd_stat :
    hit_irq_en ? rd_en :
    hit_chan_stat ? rd_chan :
    RDATA_ZERO;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= RDATA_ZERO;
    end else begin
      wb_ack_o <= first;
      wb_dat_o <= (first & ~wb_we_i) ? next_rdata : RDATA_ZERO;
    end
  end

  // --------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------
  wire [2:0] strb_w = (wr & hit_strobe) ? wbyte[2:0] : STROBE_RST;
  wire [2:0] clr_w = (wr & hit_irq_clr) ? wbyte[2:0] : 3'h0;
  wire [2:0] clr_bits = strb | clr_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aiao_sel <= SEL_RST;
      ctr_sel <= SEL_RST;
      strb <= STROBE_RST;
      irq_en <= IRQ_EN_RST;
    end else begin
      strb <= strb_w;
      if (wr & hit_aiao) begin
        aiao_sel <= wbyte;
      end
      if (wr & hit_ctr) begin
        ctr_sel <= wbyte;
      end
      if (wr & hit_irq_en) begin
        irq_en <= wbyte[2:0];
      end
    end
  end

  // --------------------------------------------------------------
  // Logical channels
  // --------------------------------------------------------------
  generate
    for (genvar k = 0; k < LCH_N; k++) begin : g_ch
      wire hit_mode = idx == IDX_MODES[k*6 +: 6];
      wire [2:0] phys = mode[k].phys;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mode[k] <= MODE_RST;
        end else if (wr & hit_mode) begin
          mode[k] <= wbyte;
        end
      end

      // Resources bound to this channel
      assign lreq[k] = (res_req_i.ai & aiao_sel[SEL_IN_LSB + k])
        | (res_req_i.ao & aiao_sel[SEL_OUT_LSB + k])
        | (res_req_i.g0 & ctr_sel[SEL_IN_LSB + k])
        | (res_req_i.g1 & ctr_sel[SEL_OUT_LSB + k]);
      assign on_vec[k] = mode[k].on;
      assign irq_on_vec[k] = mode[k].irq_on;

      ldc_chan #(
        .BURST_LEN(BURST_LEN)
      ) u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode[k]),
        .lreq_i(lreq[k]),
        .dack_i(dack_f[phys]),
        .tc_i(tc_f),
        .drq_o(drq_c[k]),
        .lack_o(lack[k]),
        .tc_ev_o(tc_ev[k])
      );
    end
  endgenerate

  // --------------------------------------------------------------
  // Physical routing
  // --------------------------------------------------------------
  always_comb begin
    next_drq = '0;
    for (int k = 0; k < LCH_N; k++) begin
      if (drq_c[k]) begin
        next_drq[mode[k].phys] = 1'b1;
      end
    end
  end

  always_comb begin
    next_res_ack.ai = |(lack & aiao_sel[SEL_IN_LSB +: LCH_N]);
    next_res_ack.ao = |(lack & aiao_sel[SEL_OUT_LSB +: LCH_N]);
    next_res_ack.g0 = |(lack & ctr_sel[SEL_IN_LSB +: LCH_N]);
    next_res_ack.g1 = |(lack & ctr_sel[SEL_OUT_LSB +: LCH_N]);
  end

  // --------------------------------------------------------------
  // Terminal count and interrupt
  // --------------------------------------------------------------
  wire [2:0] irq_src = tc_stat & irq_en & irq_on_vec;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tc_stat <= 3'h0;
      drq_o <= '0;
      res_ack_o <= '0;
      irq_o <= 1'b0;
    end else begin
      tc_stat <= (tc_stat & ~clr_bits) | tc_ev;
      drq_o <= next_drq;
      res_ack_o <= next_res_ack;
      irq_o <= |irq_src;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  chk_reset_zero: assert property (disable iff (1'b0)
    rst_i |=> mode[0] == MODE_RST && mode[1] == MODE_RST && strb == STROBE_RST)
    else $error("registers not zero after reset");

  chk_strobe_clear: assert property (
    |strb |=> strb == STROBE_RST)
    else $error("strobe did not self clear");

  chk_tc_clear: assert property (
    strb[0] && !tc_ev[0] |=> !tc_stat[0])
    else $error("strobe did not clear channel A status");

  chk_tc_set: assert property (
    tc_ev[1] |=> tc_stat[1])
    else $error("terminal count did not set status");

  chk_irq_cause: assert property (
    irq_o |-> $past(|irq_src))
    else $error("interrupt without enabled cause");

  chk_irq_raise: assert property (
    tc_stat[0] && irq_en[0] && irq_on_vec[0] |=> irq_o)
    else $error("enabled terminal count gave no interrupt");

  chk_mode_b_write: assert property (
    wr && idx == IDX_MODE_B |=> mode[1] == $past(wbyte))
    else $error("mode B write not stored");

  chk_all_off: assert property (
    on_vec == 3'h0 [*2] |=> drq_o == '0)
    else $error("request with all channels disabled");

  chk_route_drq: assert property (
    drq_c[0] |=> drq_o[$past(mode[0].phys)])
    else $error("request not on selected line");

  chk_rdata_idle: assert property (
    !wb_ack_o |-> wb_dat_o == RDATA_ZERO)
    else $error("read data not zero outside ack");

  chk_ack_cause: assert property (
    wb_ack_o |-> $past(first))
    else $error("ack without a request");

  chk_strobe_load: assert property (
    wr && hit_strobe |=> strb == $past(wbyte[2:0]))
    else $error("strobe write not taken");

  chk_tc_quiet: assert property (
    tc_stat == 3'h0 |=> !irq_o)
    else $error("interrupt with all status clear");

  chk_irq_mask: assert property (
    (tc_stat & irq_on_vec) == 3'h0 |=> !irq_o)
    else $error("interrupt from a masked channel");

  chk_en_write: assert property (
    wr && hit_irq_en |=> irq_en == $past(wbyte[2:0]))
    else $error("interrupt enable write not stored");

  chk_drq_idle: assert property (
    drq_c == '0 |=> drq_o == '0)
    else $error("physical request without channel request");

  chk_lreq_quiet: assert property (
    res_req_i == '0 |-> lreq == '0)
    else $error("logical request without resource request");

  chk_unbound_quiet: assert property (
    aiao_sel == SEL_RST && ctr_sel == SEL_RST |-> lreq == '0)
    else $error("unbound resource reached a channel");

  chk_sel_write: assert property (
    wr && hit_aiao |=> aiao_sel == $past(wbyte))
    else $error("select write not stored");

  chk_ack_off: assert property (
    on_vec == '0 |=> res_ack_o == '0)
    else $error("acknowledge through disabled channels");

  chk_ack_ai: assert property (
    lack[0] && aiao_sel[SEL_IN_LSB] |=> res_ack_o.ai)
    else $error("acknowledge not routed to analog input");

  chk_tc_cause: assert property (
    tc_ev != '0 |-> tc_f && dack_f != '0)
    else $error("terminal count event without acknowledge");

  chk_stat_sticky: assert property (
    tc_stat[0] && !clr_bits[0] |=> tc_stat[0])
    else $error("status dropped without clear");

  chk_mode_c_write: assert property (
    wr && idx == IDX_MODE_C |=> mode[2] == $past(wbyte))
    else $error("mode C write not stored");

  chk_route_one: assert property (
    drq_c == 3'h1 |=> $onehot(drq_o))
    else $error("one channel drove several lines");

  cov_tc_event: cover property (tc_ev[0]);
  cov_irq_rise: cover property (!irq_o ##1 irq_o);
  cov_strobe_clear: cover property (tc_stat[2] ##1 strb[2] ##1 !tc_stat[2]);
  cov_res_route: cover property (res_ack_o.g1);

endmodule // ldc_top

/* File: test/ldc_host_model.sv */
// Purpose: Host DMA controller model answering physical request lines
// Assumes: One transfer in flight at a time, lowest request line served first
// Notes: Acknowledge and terminal count idle low between transfers
`timescale 1ns/1ps
module ldc_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] drq_i,
  input wire logic [1:0] lat_i,
  input wire logic tc_on_i,
  output logic [7:0] dack_o,
  output logic tc_o
);
  int k;
  int n;
  initial begin
    dack_o = 8'h00;
    tc_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (!rst_i && drq_i != 8'h00) begin
        k = 0;
        while (!drq_i[k]) k++;
        repeat (lat_i + 1) @(posedge clk_i);
        dack_o[k] <= 1'b1;
        tc_o <= tc_on_i;
        n = 0;
        // A burst keeps its request up, so the acknowledge ends after a fixed hold
        while (drq_i[k] && n < 8) begin
          @(posedge clk_i);
          n++;
        end
        dack_o <= 8'h00;
        tc_o <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
    end
  end
endmodule // ldc_host_model

/* File: test/tb_ldc_top.sv */
// Purpose: Self-checking bench of the logical DMA channel router
// Assumes: Host model answers every request; burst length reduced to 2
// Notes: Register reads are compared against a queue of expected values
`timescale 1ns/1ps
module tb_ldc_top;
  import ldc_pkg::*;
  localparam int unsigned BLEN = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  ldc_res_t req = 4'h0;
  ldc_res_t rack;
  logic [7:0] drq;
  logic [7:0] dack;
  logic tc;
  logic irq;
  logic tc_on = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [31:0] rng = 32'hD3C6B352;
  logic [31:0] expq[$];
  logic [5:0] ridx [8] = '{IDX_STROBE, IDX_MODE_A, IDX_MODE_B, IDX_MODE_C, IDX_AIAO_SEL, IDX_CHAN_STAT,
                           IDX_IRQ_STAT, 6'h3F};
  logic [2:0] phys;
  logic drq_d = 1'b0;
  logic dack_d = 1'b0;
  int bad_count = 0;
  int n_tests = 0;
  int rises = 0;
  int acks = 0;
  int n;
  int r0;
  int a0;

  always #12.5 clk_i = ~clk_i;

  ldc_top #(.BURST_LEN(BLEN)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .res_req_i(req), .res_ack_o(rack), .drq_o(drq), .dack_i(dack), .tc_i(tc), .irq_o(irq));
  ldc_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .drq_i(drq), .lat_i(lat), .tc_on_i(tc_on),
    .dack_o(dack), .tc_o(tc));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    $display("ERROR %0t %s", $time, m);
    bad_count++;
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) fail("read data mismatch");
  endtask

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) fail("output mismatch");
  endtask

  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s);
    int c;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (ack !== 1'b1 && c < 50);
    if (ack !== 1'b1) begin
      fail("bus timeout");
      wrap_up();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'hF);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    expq.push_back({24'h000000, e});
    wb(1'b0, idx, 8'h00, 4'hF);
  endtask

  // Waits on drq line w (0..7), irq (8) or any resource acknowledge (9)
  task automatic wait_bit(input int w, input logic v);
    int c;
    logic s;
    c = 0;
    do begin
      @(posedge clk_i);
      s = (w < 8) ? drq[w] : (w == 8) ? irq : |rack;
      c++;
    end while (s !== v && c < 200);
    if (s !== v) begin
      fail("wait timeout");
      wrap_up();
    end
  endtask

  task automatic xfer(input int k, input logic t, input ldc_res_t r);
    lat <= rng[1:0];
    tc_on <= t;
    req <= r;
    wait_bit(k, 1'b1);
    wait_bit(9, 1'b1);
    chk_out({4'h0, rack}, {4'h0, r});
    chk_out(drq, 8'h01 << k);
    wait_bit(k, 1'b0);
    req <= 4'h0;
    tc_on <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    drq_d <= drq[5];
    dack_d <= dack[5];
    if (drq[5] === 1'b1 && drq_d === 1'b0) rises <= rises + 1;
    if (dack[5] === 1'b1 && dack_d === 1'b0) acks <= acks + 1;
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) fail("unexpected read");
      else chk_rd(rdat, expq.pop_front());
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    foreach (ridx[i]) rd(ridx[i], 8'h00);
    rd(IDX_IRQ_EN, 8'h07);
    wr(IDX_AIAO_SEL, 8'h01);
    wb(1'b1, IDX_MODE_A, 8'h85, 4'hE);
    req <= 4'h1;
    repeat (20) @(posedge clk_i);
    chk_out(drq, 8'h00);
    req <= 4'h0;
    for (int c = 0; c < 3; c++) begin
      rng = xs(rng);
      phys = 3'h5 + 3'(rng % 3);
      wr(IDX_AIAO_SEL, 8'h01 << c);
      wr(IDX_MODE_A + 6'(2 * c), {2'b00, XFER_SINGLE, phys});
      wr(IDX_MODE_A + 6'(2 * c), {1'b1, c == 0, XFER_SINGLE, phys});
      xfer(int'(phys), 1'b1, 4'h1);
      if (c == 0) wait_bit(8, 1'b1);
      repeat (30) @(posedge clk_i);
      chk_out({7'h00, irq}, {7'h00, c == 0});
      rd(IDX_IRQ_STAT, 8'h01 << c);
      wr(IDX_STROBE, 8'h01 << c);
      repeat (4) @(posedge clk_i);
      chk_out({7'h00, irq}, 8'h00);
      rd(IDX_IRQ_STAT, 8'h00);
      wr(IDX_MODE_A + 6'(2 * c), 8'h00);
    end
    wr(IDX_AIAO_SEL, 8'h00);
    wr(IDX_CTR_SEL, 8'h10);
    wr(IDX_MODE_A, 8'h85);
    xfer(5, 1'b0, 4'h8);
    wr(IDX_MODE_A, 8'h00);
    wr(IDX_CTR_SEL, 8'h00);
    wr(IDX_AIAO_SEL, 8'h01);
    wr(IDX_MODE_A, 8'hC5);
    xfer(5, 1'b1, 4'h1);
    wait_bit(8, 1'b1);
    wr(IDX_IRQ_EN, 8'h00);
    rd(IDX_IRQ_EN, 8'h00);
    wait_bit(8, 1'b0);
    wr(IDX_IRQ_EN, 8'h07);
    wait_bit(8, 1'b1);
    wr(IDX_IRQ_CLR, 8'h01);
    wait_bit(8, 1'b0);
    rd(IDX_IRQ_STAT, 8'h00);
    for (int b = 0; b < 2; b++) begin
      wr(IDX_MODE_A, 8'h00);
      wr(IDX_MODE_A, {2'b10, (b == 0) ? XFER_SINGLE : XFER_BURST, 3'h5});
      r0 = rises;
      a0 = acks;
      req <= 4'h1;
      n = 0;
      while (acks - a0 < 4 && n < 400) begin
        @(posedge clk_i);
        n++;
      end
      req <= 4'h0;
      if (acks - a0 < 4) begin
        fail("acknowledge count timeout");
        wrap_up();
      end
      chk_out(8'(rises - r0), (b == 0) ? 8'h04 : 8'(4 / BLEN));
      wait_bit(5, 1'b0);
      repeat (12) @(posedge clk_i);
    end
    wr(IDX_MODE_A, 8'h00);
    rd(IDX_IRQ_STAT, 8'h00);
    repeat (2) @(posedge clk_i);
    if (expq.size() != 0) fail("read left unanswered");
    wrap_up();
  end
endmodule // tb_ldc_top
